//--- bench/psl_eep_model.sv
// Behavioural serial EEPROM for product-data cycles
`timescale 1ns/100ps
module psl_eep_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic eep_req,
   input wire logic eep_we,
   input wire logic [7:0] eep_addr,
   input wire logic [31:0] eep_wdata,
   input wire logic [3:0] lat,
   output logic eep_ack,
   output logic [31:0] eep_rdata
);
   logic [31:0] mem [256];
   logic [3:0] cnt;
   logic hold;
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = 32'hc0de_0000 | 32'(i);
      end
   end
   // Data toggles outside the ack cycle so a late sample shows
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         {eep_ack, hold, cnt} <= '0;
         eep_rdata <= 32'h5a5a_5a5a;
      end else begin
         eep_ack <= 1'b0;
         eep_rdata <= ~eep_rdata;
         if (!eep_req) begin
            {hold, cnt} <= '0;
         end else if (!hold && cnt == lat) begin
            eep_ack <= 1'b1;
            hold <= 1'b1;
            if (eep_we) begin
               mem[eep_addr] <= eep_wdata;
            end else begin
               eep_rdata <= mem[eep_addr];
            end
         end else if (!hold) begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule // psl_eep_model

//--- bench/psl_regs_assertions.sv
// Port checks for the register group
`timescale 1ns/100ps
module psl_regs_assertions
   import psl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic cfg_ack,
   input wire logic fts_sym_valid,
   input wire logic [7:0] fts_sym,
   input wire logic fts_sym_is_k,
   input wire logic receive_diff_pair_p_in,
   input wire logic receive_diff_pair_n_in,
   input wire logic receive_diff_pair_p,
   input wire logic receive_diff_pair_n,
   input wire logic link_idle_l0,
   input wire logic l1_enter_req,
   input wire logic eep_req,
   input wire logic eep_ack,
   input wire logic [7:0] eep_addr
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   a_ack_follows: assert property ((cfg_wr || cfg_rd) |=> cfg_ack)
      else $error("ack missing");
   a_ack_single: assert property (!(cfg_wr || cfg_rd) |=> !cfg_ack)
      else $error("stray ack");
   a_fts_comma: assert property ($rose(fts_sym_valid)
      |-> fts_sym_is_k && fts_sym == SYM_K28_5)
      else $error("set not opened by comma");
   a_fts_set_body: assert property (fts_sym_valid && fts_sym == SYM_K28_5
      |=> (fts_sym_valid && fts_sym == SYM_K28_1)[*3])
      else $error("set body wrong");
   a_rx_pair_split: assert property ((receive_diff_pair_p_in != receive_diff_pair_n_in)
      |=> (receive_diff_pair_p != receive_diff_pair_n))
      else $error("pair merged");
   a_req_held: assert property (eep_req && !eep_ack |=> eep_req)
      else $error("request dropped early");
   a_eep_base: assert property (eep_req |-> eep_addr[7:6] == VPD_EEP_BASE)
      else $error("eeprom offset wrong");
   a_idle_drop: assert property (!link_idle_l0 |=> !l1_enter_req)
      else $error("l1 request without idle");
   cover property ($rose(fts_sym_valid));
   cover property (eep_ack && eep_req);
   cover property ($rose(l1_enter_req));
endmodule // psl_regs_assertions
bind psl_regs psl_regs_assertions psl_regs_assertions_inst (.*);

//--- bench/psl_regs_tb_top.sv
// Self-checking bench for the register group
`timescale 1ns/100ps
module psl_regs_tb_top
   import psl_pkg::*;
;
   logic clk_sys, rst_n, cfg_wr, cfg_rd, cfg_ack, fts_request, link_idle_l0, eep_ack, eep_req;
   logic receive_diff_pair_p_in, receive_diff_pair_n_in, receive_diff_pair_p, receive_diff_pair_n;
   logic hp_attn_pressed, hp_power_fault, hp_latch_changed, hp_presence_changed, eep_we;
   logic hp_cmd_completed, hp_latch_state, hp_presence_state, slot_int_req, power_ctrl;
   logic hot_reset_en, loopback_en, crosslink_en, direct_to_config, debug_sel;
   logic fts_sym_is_k, fts_sym_valid, fts_busy, l1_enter_req;
   logic [1:0] attn_indicator, power_indicator;
   logic [2:0] lane_retry_count;
   logic [3:0] cfg_be, lat;
   logic [4:0] ts1_count;
   logic [6:0] l0s_exit_latency, l1_exit_latency, hp;
   logic [7:0] cfg_addr, fts_sym, eep_addr;
   logic [8:0] l1_wait_ms;
   logic [9:0] l0s_lifetime;
   logic [15:0] l1_timer_reload, l1_lifetime;
   logic [31:0] cfg_wdata, cfg_rdata, eep_wdata, eep_rdata, rd;
   int fail_count, samples_checked;
   assign {hp_presence_state, hp_latch_state, hp_cmd_completed, hp_presence_changed,
      hp_latch_changed, hp_power_fault, hp_attn_pressed} = hp;
   // Short millisecond keeps the wait period inside the run
   psl_regs #(.CYCLES_PER_MS(4)) psl_regs_inst (.*);
   psl_eep_model psl_eep_model_inst (.*);
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] d);
      {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {w, !w, a, be, d};
      cyc(1);
      {cfg_wr, cfg_rd} = 2'b00;
      chk({31'h0, cfg_ack}, 32'h1);
      rd = cfg_rdata;
      // Idle edge so no strobe is set twice in one time step
      cyc(1);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, a, 4'h0, 32'h0);
      chk(rd, e);
   endtask
   task automatic poll(input logic v);
      int n;
      n = 0;
      do begin
         acc(1'b0, 8'hd8, 4'h0, 32'h0);
         n++;
      end while (rd[31] !== v && n < 40);
      chk({31'h0, rd[31]}, {31'h0, v});
   endtask
   task automatic t_regs();
      rc(8'hc8, 32'h0);
      rc(8'hcc, 32'h0400_1060);
      rc(8'hd4, 32'h0019_0254);
      rc(8'h80, 32'h0);
      rc(8'hd0, 32'h0);
      acc(1'b1, 8'hd0, 4'hf, '1);
      rc(8'hd0, 32'hffff_03ff);
      chk({6'h0, l0s_lifetime, l1_lifetime}, 32'h03ff_ffff);
      acc(1'b1, 8'hc8, 4'hf, '1);
      rc(8'hc8, 32'h0000_07ff);
      chk({27'h0, attn_indicator, power_indicator, power_ctrl}, 32'h1f);
      acc(1'b1, 8'hcc, 4'hf, '1);
      rc(8'hcc, 32'hffff_1fff);
      chk({4'h0, hot_reset_en, loopback_en, crosslink_en, direct_to_config,
         lane_retry_count, ts1_count, l1_timer_reload}, 32'h0fff_ffff);
      acc(1'b1, 8'hd4, 4'h7, '1);
      rc(8'hd4, 32'h007f_ffff);
      chk({18'h0, l0s_exit_latency, l1_exit_latency}, 32'h3fff);
      acc(1'b1, 8'hd8, 4'h3, '1);
      rc(8'hd8, 32'h0000_f003);
      $display("test regs done");
   endtask
   task automatic t_slot();
      hp = 7'h7f;
      cyc(3);
      rc(8'hc8, 32'h007f_07ff);
      chk({31'h0, slot_int_req}, 32'h1);
      acc(1'b1, 8'hc8, 4'h1, 32'h20);
      cyc(3);
      chk({31'h0, slot_int_req}, 32'h0);
      acc(1'b1, 8'hc8, 4'h1, 32'h10);
      cyc(3);
      chk({31'h0, slot_int_req}, 32'h1);
      hp = 7'h00;
      $display("test slot done");
   endtask
   task automatic t_phy();
      int n;
      logic [7:0] c[4] = '{8'h00, 8'h01, 8'h80, 8'hff};
      logic [8:0] e[4] = '{9'd128, 9'd129, 9'd0, 9'd127};
      {receive_diff_pair_p_in, receive_diff_pair_n_in} = 2'b10;
      cyc(2);
      chk({30'h0, receive_diff_pair_p, receive_diff_pair_n}, 32'h1);
      acc(1'b1, 8'hd4, 4'h3, 32'h0000_0202);
      cyc(2);
      chk({30'h0, receive_diff_pair_p, receive_diff_pair_n}, 32'h2);
      fts_request = 1'b1;
      cyc(1);
      fts_request = 1'b0;
      n = 0;
      while (fts_sym_valid !== 1'b1 && n < 8) begin
         cyc(1);
         n++;
      end
      chk({31'h0, fts_busy}, 32'h1);
      for (int i = 0; i < 8; i++) begin
         chk({23'h0, fts_sym_is_k, fts_sym}, (i % 4 == 0) ? 32'h1bc : 32'h13c);
         cyc(1);
      end
      chk({31'h0, fts_sym_valid}, 32'h0);
      chk({31'h0, fts_busy}, 32'h0);
      for (int i = 0; i < 4; i++) begin
         acc(1'b1, 8'hd4, 4'h8, {c[i], 24'h0});
         cyc(2);
         chk({23'h0, l1_wait_ms}, {23'h0, e[i]});
      end
      acc(1'b1, 8'hd4, 4'h8, 32'h8100_0000);
      link_idle_l0 = 1'b1;
      cyc(2);
      chk({31'h0, l1_enter_req}, 32'h0);
      cyc(8);
      chk({31'h0, l1_enter_req}, 32'h1);
      link_idle_l0 = 1'b0;
      $display("test phy done");
   endtask
   task automatic t_vpd();
      acc(1'b1, 8'hd8, 4'hf, 32'h0014_0000);
      cyc(2);
      acc(1'b1, 8'hd8, 4'hf, 32'h0024_0000);
      poll(1'b1);
      chk(rd, 32'h8014_f003);
      rc(8'hec, 32'hc0de_0045);
      lat = 4'h0;
      acc(1'b1, 8'hec, 4'hf, 32'h1234_5678);
      acc(1'b1, 8'hd8, 4'hf, 32'h8014_0000);
      poll(1'b0);
      acc(1'b1, 8'hd8, 4'hf, 32'h0014_0000);
      poll(1'b1);
      rc(8'hec, 32'h1234_5678);
      $display("test vpd done");
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      fail_count++;
      end_sim();
   end
   initial begin
      {rst_n, cfg_wr, cfg_rd, fts_request, link_idle_l0, cfg_addr, cfg_be, cfg_wdata} = '0;
      {hp, receive_diff_pair_p_in, receive_diff_pair_n_in} = '0;
      lat = 4'h3;
      cyc(3);
      rst_n = 1'b1;
      t_regs();
      t_slot();
      t_phy();
      t_vpd();
      end_sim();
   end
endmodule // psl_regs_tb_top

//--- verilog/psl_eep_engine.sv
// EEPROM cycle engine for product-data reads and writes
`timescale 1ns/100ps
module psl_eep_engine
   import psl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   psl_vpd_if.eng vpd,
   output logic eep_req,
   output logic eep_we,
   output logic [7:0] eep_addr,
   output logic [31:0] eep_wdata,
   input wire logic eep_ack,
   input wire logic [31:0] eep_rdata
);
   psl_eep_state_e state;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state <= PSL_EEP_IDLE;
         eep_we <= 1'b0;
         eep_addr <= 8'h00;
         eep_wdata <= 32'h0000_0000;
      end else begin
         case (state)
            PSL_EEP_IDLE: if (vpd.start) begin
               state <= PSL_EEP_BUSY;
               eep_we <= vpd.we;
               eep_addr <= vpd.addr;
               eep_wdata <= vpd.wdata;
            end
            PSL_EEP_BUSY: if (eep_ack) state <= PSL_EEP_IDLE;
            default: state <= PSL_EEP_IDLE;
         endcase
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         vpd.rdata <= 32'h0000_0000;
         vpd.done <= 1'b0;
      end else begin
         vpd.done <= (state == PSL_EEP_BUSY) && eep_ack;
         if ((state == PSL_EEP_BUSY) && eep_ack && !eep_we) vpd.rdata <= eep_rdata;
      end
   end
   assign eep_req = (state == PSL_EEP_BUSY);
   // Start cycle counts as busy so a back-to-back write cannot retarget the op
   assign vpd.busy = (state != PSL_EEP_IDLE) || vpd.start || vpd.done;
endmodule // psl_eep_engine

//--- verilog/psl_fts_gen.sv
// Fast training sequence symbol generator
`timescale 1ns/100ps
module psl_fts_gen
   import psl_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [7:0] set_count,
   output logic [7:0] sym,
   output logic sym_is_k,
   output logic sym_valid,
   output logic busy
);
   logic [7:0] sets_left;
   logic [1:0] sym_idx;
   assign busy = (sets_left != 8'h00);
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sets_left <= 8'h00;
         sym_idx <= 2'h0;
      end else if (!busy) begin
         sets_left <= start ? set_count : 8'h00;
         sym_idx <= 2'h0;
      end else begin
         sym_idx <= sym_idx + 2'h1;
         if (sym_idx == FTS_LAST_SYM) sets_left <= sets_left - 8'h01;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sym <= 8'h00;
         sym_is_k <= 1'b0;
         sym_valid <= 1'b0;
      end else begin
         sym_valid <= busy;
         sym_is_k <= busy;
         sym <= !busy ? 8'h00 : (sym_idx == 2'h0) ? SYM_K28_5 : SYM_K28_1;
      end
   end
endmodule // psl_fts_gen

//--- verilog/psl_pkg.sv
// Constants and types of the slot, phy tuning and product-data register group
package psl_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_SLOT = 8'hc8;
   localparam logic [7:0] OFS_CFG0 = 8'hcc;
   localparam logic [7:0] OFS_CFG1 = 8'hd0;
   localparam logic [7:0] OFS_CFG2 = 8'hd4;
   localparam logic [7:0] OFS_VPD = 8'hd8;
   localparam logic [7:0] OFS_VPD_DATA = 8'hec;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int SC_EVT_LSB = 0;
   localparam int SC_CMD_INT_EN = 4;
   localparam int SC_HP_INT_EN = 5;
   localparam int SS_LSB = 16;
   localparam int SS_CMD_DONE = 4;
   localparam int C0_RETRY_LSB = 5;
   localparam int C0_TS1_LSB = 8;
   localparam int C0_L1_RELOAD_LSB = 16;
   localparam int C1_L1_LIFE_LSB = 16;
   localparam int C2_L0S_EXIT_LSB = 8;
   localparam int C2_RX_INV = 15;
   localparam int C2_L1_EXIT_LSB = 16;
   localparam int C2_WAIT_LSB = 24;
   localparam int VPD_ADDR_LSB = 18;
   localparam int VPD_FLAG = 31;
   // ---------------------------------------------------------------
   // Reset and fixed values
   // ---------------------------------------------------------------
   localparam logic [2:0] RST_RETRY = 3'h3;
   localparam logic [4:0] RST_TS1 = 5'h10;
   localparam logic [15:0] RST_L1_RELOAD = 16'h0400;
   localparam logic [7:0] RST_CDR_FTS = 8'h54;
   localparam logic [6:0] RST_L0S_EXIT = 7'h02;
   localparam logic [6:0] RST_L1_EXIT = 7'h19;
   localparam logic [7:0] RST_WAIT = 8'h00;
   localparam logic [7:0] VPD_CAP_ID = 8'h03;
   localparam logic [7:0] VPD_NEXT_PTR = 8'hf0;
   localparam logic [1:0] VPD_EEP_BASE = 2'h1;
   localparam logic [7:0] WAIT_HALF = 8'h80;
   localparam logic [8:0] WAIT_BASE_MS = 9'h080;
   localparam logic [7:0] SYM_K28_5 = 8'hbc;
   localparam logic [7:0] SYM_K28_1 = 8'h3c;
   localparam logic [1:0] FTS_LAST_SYM = 2'h3;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int MS_IN_NS = 1000000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int CYC_PER_MS = MS_IN_NS / CLK_PERIOD_NS;
   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      PSL_EEP_IDLE = 2'b00,
      PSL_EEP_BUSY = 2'b01
   } psl_eep_state_e;
endpackage

//--- verilog/psl_regs.sv
// Slot, phy tuning and product-data configuration register group
`timescale 1ns/100ps
module psl_regs
   import psl_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic [31:0] cfg_rdata,
   output logic cfg_ack,
   input wire logic hp_attn_pressed,
   input wire logic hp_power_fault,
   input wire logic hp_latch_changed,
   input wire logic hp_presence_changed,
   input wire logic hp_cmd_completed,
   input wire logic hp_latch_state,
   input wire logic hp_presence_state,
   output logic slot_int_req,
   output logic [1:0] attn_indicator,
   output logic [1:0] power_indicator,
   output logic power_ctrl,
   output logic hot_reset_en,
   output logic loopback_en,
   output logic crosslink_en,
   output logic direct_to_config,
   output logic debug_sel,
   output logic [2:0] lane_retry_count,
   output logic [4:0] ts1_count,
   output logic [15:0] l1_timer_reload,
   output logic [9:0] l0s_lifetime,
   output logic [15:0] l1_lifetime,
   output logic [6:0] l0s_exit_latency,
   output logic [6:0] l1_exit_latency,
   input wire logic fts_request,
   output logic [7:0] fts_sym,
   output logic fts_sym_is_k,
   output logic fts_sym_valid,
   output logic fts_busy,
   input wire logic receive_diff_pair_p_in,
   input wire logic receive_diff_pair_n_in,
   output logic receive_diff_pair_p,
   output logic receive_diff_pair_n,
   input wire logic link_idle_l0,
   output logic [8:0] l1_wait_ms,
   output logic l1_enter_req,
   output logic eep_req,
   output logic eep_we,
   output logic [7:0] eep_addr,
   output logic [31:0] eep_wdata,
   input wire logic eep_ack,
   input wire logic [31:0] eep_rdata
);
   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [3:0] evt_en;
   logic cmd_int_en;
   logic hp_int_en;
   logic [6:0] slot_stat;
   logic [7:0] cdr_fts_count;
   logic rx_invert;
   logic [7:0] wait_code;
   logic [5:0] vpd_addr;
   logic vpd_flag;
   logic [31:0] vpd_data;
   logic [31:0] next_rdata;
   logic [17:0] ms_div;
   logic [8:0] ms_elapsed;
   logic ms_tick;
   logic hit_slot;
   logic hit_cfg0;
   logic hit_cfg1;
   logic hit_cfg2;
   logic hit_vpd;
   logic hit_data;
   logic [15:0] slot_ctrl_word;
   psl_vpd_if vpd ();

   assign hit_slot = (cfg_addr[7:2] == OFS_SLOT[7:2]);
   assign hit_cfg0 = (cfg_addr[7:2] == OFS_CFG0[7:2]);
   assign hit_cfg1 = (cfg_addr[7:2] == OFS_CFG1[7:2]);
   assign hit_cfg2 = (cfg_addr[7:2] == OFS_CFG2[7:2]);
   assign hit_vpd = (cfg_addr[7:2] == OFS_VPD[7:2]);
   assign hit_data = (cfg_addr[7:2] == OFS_VPD_DATA[7:2]);

   // ---------------------------------------------------------------
   // Slot control and status
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         evt_en <= 4'h0;
         cmd_int_en <= 1'b0;
         hp_int_en <= 1'b0;
         attn_indicator <= 2'h0;
         power_indicator <= 2'h0;
         power_ctrl <= 1'b0;
      end else if (cfg_wr && hit_slot) begin
         if (cfg_be[0]) begin
            evt_en <= cfg_wdata[SC_EVT_LSB +: 4];
            cmd_int_en <= cfg_wdata[SC_CMD_INT_EN];
            hp_int_en <= cfg_wdata[SC_HP_INT_EN];
            attn_indicator <= cfg_wdata[7:6];
         end
         if (cfg_be[1]) begin
            power_indicator <= cfg_wdata[9:8];
            power_ctrl <= cfg_wdata[10];
         end
      end
   end

   // Status follows the hot-plug logic; writes never reach it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         slot_stat <= 7'h00;
      end else begin
         slot_stat <= {hp_presence_state, hp_latch_state, hp_cmd_completed,
                       hp_presence_changed, hp_latch_changed, hp_power_fault,
                       hp_attn_pressed};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         slot_int_req <= 1'b0;
      end else begin
         slot_int_req <= (hp_int_en && |(slot_stat[3:0] & evt_en))
                         || (cmd_int_en && slot_stat[SS_CMD_DONE]);
      end
   end

   assign slot_ctrl_word = {5'h00, power_ctrl, power_indicator, attn_indicator,
                            hp_int_en, cmd_int_en, evt_en};

   // ---------------------------------------------------------------
   // Phy tuning configuration 0 and 1
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         hot_reset_en <= 1'b0;
         loopback_en <= 1'b0;
         crosslink_en <= 1'b0;
         direct_to_config <= 1'b0;
         debug_sel <= 1'b0;
         lane_retry_count <= RST_RETRY;
         ts1_count <= RST_TS1;
         l1_timer_reload <= RST_L1_RELOAD;
      end else if (cfg_wr && hit_cfg0) begin
         if (cfg_be[0]) begin
            hot_reset_en <= cfg_wdata[0];
            loopback_en <= cfg_wdata[1];
            crosslink_en <= cfg_wdata[2];
            direct_to_config <= cfg_wdata[3];
            debug_sel <= cfg_wdata[4];
            lane_retry_count <= cfg_wdata[C0_RETRY_LSB +: 3];
         end
         if (cfg_be[1]) ts1_count <= cfg_wdata[C0_TS1_LSB +: 5];
         if (cfg_be[2]) l1_timer_reload[7:0] <= cfg_wdata[23:16];
         if (cfg_be[3]) l1_timer_reload[15:8] <= cfg_wdata[31:24];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         l0s_lifetime <= 10'h000;
         l1_lifetime <= 16'h0000;
      end else if (cfg_wr && hit_cfg1) begin
         if (cfg_be[0]) l0s_lifetime[7:0] <= cfg_wdata[7:0];
         if (cfg_be[1]) l0s_lifetime[9:8] <= cfg_wdata[9:8];
         if (cfg_be[2]) l1_lifetime[7:0] <= cfg_wdata[23:16];
         if (cfg_be[3]) l1_lifetime[15:8] <= cfg_wdata[31:24];
      end
   end

   // ---------------------------------------------------------------
   // Phy tuning configuration 2 and waiting period
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cdr_fts_count <= RST_CDR_FTS;
         l0s_exit_latency <= RST_L0S_EXIT;
         rx_invert <= 1'b0;
         l1_exit_latency <= RST_L1_EXIT;
         wait_code <= RST_WAIT;
      end else if (cfg_wr && hit_cfg2) begin
         if (cfg_be[0]) cdr_fts_count <= cfg_wdata[7:0];
         if (cfg_be[1]) begin
            l0s_exit_latency <= cfg_wdata[C2_L0S_EXIT_LSB +: 7];
            rx_invert <= cfg_wdata[C2_RX_INV];
         end
         if (cfg_be[2]) l1_exit_latency <= cfg_wdata[C2_L1_EXIT_LSB +: 7];
         if (cfg_be[3]) wait_code <= cfg_wdata[C2_WAIT_LSB +: 8];
      end
   end

   // Pair swap is registered so the receiver sees one clean retimed level
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         receive_diff_pair_p <= 1'b0;
         receive_diff_pair_n <= 1'b1;
      end else begin
         receive_diff_pair_p <= rx_invert ? receive_diff_pair_n_in
                                          : receive_diff_pair_p_in;
         receive_diff_pair_n <= rx_invert ? receive_diff_pair_p_in
                                          : receive_diff_pair_n_in;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         l1_wait_ms <= WAIT_BASE_MS;
      end else if (wait_code < WAIT_HALF) begin
         l1_wait_ms <= WAIT_BASE_MS + {1'b0, wait_code};
      end else begin
         l1_wait_ms <= {1'b0, wait_code - WAIT_HALF};
      end
   end

   // Millisecond prescaler; runs only while the link idles in L0
   assign ms_tick = (ms_div == 18'(CYCLES_PER_MS - 1));
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ms_div <= 18'h00000;
      end else if (!link_idle_l0 || ms_tick) begin
         ms_div <= 18'h00000;
      end else begin
         ms_div <= ms_div + 18'h00001;
      end
   end

   // Elapsed count saturates at the request point to avoid wrap
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ms_elapsed <= 9'h000;
         l1_enter_req <= 1'b0;
      end else if (!link_idle_l0) begin
         ms_elapsed <= 9'h000;
         l1_enter_req <= 1'b0;
      end else begin
         if (ms_tick && (ms_elapsed < l1_wait_ms)) ms_elapsed <= ms_elapsed + 9'h001;
         l1_enter_req <= (ms_elapsed >= l1_wait_ms);
      end
   end

   // ---------------------------------------------------------------
   // Product-data address, flag and data
   // ---------------------------------------------------------------
   // A new operation is only accepted while the engine is idle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         vpd_addr <= 6'h00;
         vpd_flag <= 1'b0;
      end else if (vpd.done) begin
         vpd_flag <= ~vpd_flag;
      end else if (cfg_wr && hit_vpd && !vpd.busy) begin
         if (cfg_be[2]) vpd_addr <= cfg_wdata[VPD_ADDR_LSB +: 6];
         if (cfg_be[3]) vpd_flag <= cfg_wdata[VPD_FLAG];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         vpd.start <= 1'b0;
         vpd.we <= 1'b0;
         vpd.addr <= 8'h00;
         vpd.wdata <= 32'h0000_0000;
      end else begin
         vpd.start <= cfg_wr && hit_vpd && cfg_be[3] && !vpd.busy && !vpd.start;
         if (cfg_wr && hit_vpd && cfg_be[3] && !vpd.busy) begin
            vpd.we <= cfg_wdata[VPD_FLAG];
            vpd.addr <= {VPD_EEP_BASE, (cfg_be[2] ? cfg_wdata[VPD_ADDR_LSB +: 6]
                                                  : vpd_addr)};
            vpd.wdata <= vpd_data;
         end
      end
   end

   // Data register loads per byte from software, whole word from a read
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         vpd_data <= 32'h0000_0000;
      end else if (vpd.done && !vpd.we) begin
         vpd_data <= vpd.rdata;
      end else if (cfg_wr && hit_data) begin
         if (cfg_be[0]) vpd_data[7:0] <= cfg_wdata[7:0];
         if (cfg_be[1]) vpd_data[15:8] <= cfg_wdata[15:8];
         if (cfg_be[2]) vpd_data[23:16] <= cfg_wdata[23:16];
         if (cfg_be[3]) vpd_data[31:24] <= cfg_wdata[31:24];
      end
   end

   // ---------------------------------------------------------------
   // Read-back
   // ---------------------------------------------------------------
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (hit_slot) begin
         next_rdata = {9'h000, slot_stat, slot_ctrl_word};
      end else if (hit_cfg0) begin
         next_rdata = {l1_timer_reload, 3'h0, ts1_count, lane_retry_count, debug_sel,
                       direct_to_config, crosslink_en, loopback_en, hot_reset_en};
      end else if (hit_cfg1) begin
         next_rdata = {l1_lifetime, 6'h00, l0s_lifetime};
      end else if (hit_cfg2) begin
         next_rdata = {wait_code, 1'b0, l1_exit_latency, rx_invert, l0s_exit_latency,
                       cdr_fts_count};
      end else if (hit_vpd) begin
         next_rdata = {vpd_flag, 7'h00, vpd_addr, 2'h0, VPD_NEXT_PTR, VPD_CAP_ID};
      end else if (hit_data) begin
         next_rdata = vpd_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_rdata <= 32'h0000_0000;
         cfg_ack <= 1'b0;
      end else begin
         cfg_ack <= cfg_rd || cfg_wr;
         if (cfg_rd) cfg_rdata <= next_rdata;
      end
   end

   // ---------------------------------------------------------------
   // Engines
   // ---------------------------------------------------------------
   psl_eep_engine u_eep (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .vpd(vpd.eng),
      .eep_req(eep_req),
      .eep_we(eep_we),
      .eep_addr(eep_addr),
      .eep_wdata(eep_wdata),
      .eep_ack(eep_ack),
      .eep_rdata(eep_rdata)
   );

   // Recovery time sets the number of sets sent per request
   psl_fts_gen u_fts (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(fts_request),
      .set_count(cdr_fts_count),
      .sym(fts_sym),
      .sym_is_k(fts_sym_is_k),
      .sym_valid(fts_sym_valid),
      .busy(fts_busy)
   );
endmodule // psl_regs

//--- verilog/psl_vpd_if.sv
// Carrier between the register group and the EEPROM cycle engine
`timescale 1ns/100ps
interface psl_vpd_if;
   logic start;
   logic we;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic busy;
   logic done;
   logic [31:0] rdata;
   modport ctrl (output start, output we, output addr, output wdata,
                 input busy, input done, input rdata);
   modport eng (input start, input we, input addr, input wdata,
                output busy, output done, output rdata);
endinterface
